// ---- hdl/clk_src_regs.svh ----
// Register offsets, field positions, reset values and timing counts of the clock source control block
`ifndef CLK_SRC_REGS_SVH
`define CLK_SRC_REGS_SVH

// Byte offsets on the register port
`define REG_IE_CLEAR 8'h00
`define REG_IE_SET 8'h04
`define REG_INT_FLAG 8'h08
`define REG_OSC_CTRL 8'h20
`define REG_FLL_CTRL 8'h24
`define REG_FLL_VALUE 8'h28
`define REG_FLL_MUL 8'h2C
`define REG_PLL_CTRL 8'h30
`define REG_PLL_RATIO 8'h34
`define REG_PLL_STATUS 8'h38

// Interrupt enable and flag bit positions
`define BIT_LOCK_TIMEOUT 17
`define BIT_LOCK_FALL 16
`define BIT_LOCK_RISE 15
`define BIT_SUPPLY_SYNC 11
`define IE_MASK 32'h00038800

// Oscillator control fields
`define OSC_ENABLE_BIT 1
`define OSC_RUN_IN_SLEEP_BIT 6
`define OSC_ON_REQUEST_BIT 7
`define OSC_CTRL_RESET 32'h00000080

// Loop control fields
`define FLL_ENABLE_BIT 1
`define FLL_MODE_BIT 2
`define FLL_CTRL_RESET 16'h0080

// PLL control and ratio fields
`define PLL_ENABLE_BIT 1
`define PLL_REF_LSB 4
`define PLL_FRAC_LSB 16

// Timing: figures in their own unit, cycle counts derived at 50 ns per cycle
`define CLK_PERIOD_NS 50
`define PLL_LOCK_NS 10000
`define PLL_TIMEOUT_NS 100000
`define OSC_SETTLE_NS 1000
`define FLL_REF_NS 10000
`define PLL_LOCK_CYC ((`PLL_LOCK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define PLL_TIMEOUT_CYC (`PLL_TIMEOUT_NS / `CLK_PERIOD_NS)
`define OSC_SETTLE_CYC ((`OSC_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FLL_REF_CYC (`FLL_REF_NS / `CLK_PERIOD_NS)

// Error at or above which the loop corrects with the coarse value
`define FLL_COARSE_THRESH 16'h0100

`endif

// ---- hdl/clk_src_pkg.sv ----
// Types shared by the clock source control block and its bench
`default_nettype none
package clk_src_pkg;

    // Oscillator enable handshake states
    typedef enum logic [1:0] {OSC_OFF, OSC_STARTING, OSC_ON, OSC_STOPPING} osc_state_e;

    // One register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } bus_req_s;

    // Whole state of the block
    typedef struct packed {
        logic [31:0] rdata;
        logic irq;
        logic [31:0] ie;
        logic [31:0] flags;
        logic pll_en;
        logic [1:0] pll_ref_sel;
        logic [11:0] pll_int;
        logic [3:0] pll_frac;
        logic pll_lock;
        logic [11:0] pll_cnt;
        logic pll_to_done;
        logic osc_en_cfg;
        logic osc_run_in_sleep;
        logic osc_on_request;
        osc_state_e osc_state;
        logic [7:0] osc_cnt;
        logic osc_run;
        logic [15:0] fll_ctrl;
        logic [5:0] coarse;
        logic [9:0] fine;
        logic [15:0] fll_count_difference;
        logic [31:0] fll_mul;
        logic [11:0] ref_cnt;
        logic [15:0] tick_cnt;
        logic req_s1;
        logic req_s2;
        logic ref_s1;
        logic ref_s2;
        logic sup_s1;
        logic sup_s2;
        logic sup_s3;
        logic tick_s1;
        logic tick_s2;
        logic tick_s3;
    } state_s;

endpackage
`default_nettype wire

// ---- hdl/system_clock_source_control.sv ----
// Clock source control: PLL lock tracking, internal oscillator handshake, frequency-locked loop, interrupt enables
//
// Summary of operation
// - PLL ratio writable while PLL runs
// - Ratio update clears lock, hardware relocks
// - Bit 17 one sets lock-timeout enable
// - Bit 16 one sets lock-fall enable
// - Bit 15 one sets lock-rise enable
// - Bit 11 one sets supply-sync-ready enable
// - Enabled set flag raises interrupt request
// - On-request mode runs oscillator only when requested
// - Otherwise enabled oscillator runs continuously
// - Run-in-sleep zero stops oscillator in standby
// - Run-in-sleep one follows on-request in standby
// - Enable bit reads settled on/off handshake state
// - Mode bit one selects closed loop
// - Closed loop reports target minus counted cycles
// - Calibration fields writable only in open loop
// - Coarse steps limited by coarse maximum step
// - Fine steps limited by fine maximum step
//
// Chosen here: the plain strobed port.
`include "clk_src_regs.svh"
`default_nettype none

module system_clock_source_control (
    input wire logic clk,
    input wire logic srst,
    input wire clk_src_pkg::bus_req_s bus_req,
    output logic [31:0] rdata,
    input wire logic osc_request,
    input wire logic standby,
    input wire logic pll_ref_ok,
    input wire logic supply_sync_done,
    input wire logic fll_out_tick,
    output logic irq,
    output logic osc_run,
    output logic pll_enable,
    output logic [1:0] pll_ref_sel,
    output logic [11:0] pll_int,
    output logic [3:0] pll_frac,
    output logic pll_lock,
    output logic fll_enable,
    output logic fll_closed_loop,
    output logic [5:0] fll_coarse,
    output logic [9:0] fll_fine
);

    localparam logic [11:0] PLL_LOCK_CYC = 12'(`PLL_LOCK_CYC);
    localparam logic [11:0] PLL_TIMEOUT_CYC = 12'(`PLL_TIMEOUT_CYC);
    localparam logic [7:0] OSC_SETTLE_CYC = 8'(`OSC_SETTLE_CYC);
    localparam logic [11:0] FLL_REF_CYC = 12'(`FLL_REF_CYC);

    clk_src_pkg::state_s cur_ff; // Registered state
    clk_src_pkg::state_s nxt_ff; // Next state

    logic wr_hit; // Write strobe alone; address compared at each use
    logic [31:0] wd; // Shorthand for write data
    logic [31:0] flag_set; // Hardware events this cycle
    logic [31:0] flag_clr; // Software clears this cycle

    logic osc_demand; // Oscillator wanted by mode and sleep state

    logic ratio_wr; // Ratio written while PLL enabled
    logic pll_start; // PLL goes from off to on

    logic fll_closed; // Loop enabled and in closed mode
    logic ref_tick; // One reference period has ended
    logic [15:0] new_fll_count_difference; // Target minus count at period end
    logic [15:0] mag; // Magnitude of the new difference
    logic [5:0] c_step; // Coarse step applied
    logic [9:0] f_step; // Fine step applied
    logic [6:0] c_sum; // Coarse value with carry for saturation
    logic [10:0] f_sum; // Fine value with carry for saturation

    // Outputs come straight from the state register
    assign rdata = cur_ff.rdata;
    assign irq = cur_ff.irq;
    assign osc_run = cur_ff.osc_run;
    assign pll_enable = cur_ff.pll_en;
    assign pll_ref_sel = cur_ff.pll_ref_sel;
    assign pll_int = cur_ff.pll_int;
    assign pll_frac = cur_ff.pll_frac;
    assign pll_lock = cur_ff.pll_lock;
    assign fll_enable = cur_ff.fll_ctrl[`FLL_ENABLE_BIT];
    assign fll_closed_loop = cur_ff.fll_ctrl[`FLL_MODE_BIT];
    assign fll_coarse = cur_ff.coarse;
    assign fll_fine = cur_ff.fine;

    // Next-state logic for the whole block
    always_comb begin
        nxt_ff = cur_ff;
        wd = bus_req.wdata;
        wr_hit = bus_req.wr;
        flag_set = 32'h00000000;
        flag_clr = 32'h00000000;

        // Two-stage synchronisers; edge detection looks only at the second stage onward
        nxt_ff.req_s1 = osc_request;
        nxt_ff.req_s2 = cur_ff.req_s1;
        nxt_ff.ref_s1 = pll_ref_ok;
        nxt_ff.ref_s2 = cur_ff.ref_s1;
        nxt_ff.sup_s1 = supply_sync_done;
        nxt_ff.sup_s2 = cur_ff.sup_s1;
        nxt_ff.sup_s3 = cur_ff.sup_s2;
        nxt_ff.tick_s1 = fll_out_tick;
        nxt_ff.tick_s2 = cur_ff.tick_s1;
        nxt_ff.tick_s3 = cur_ff.tick_s2;

        // Read data stands in the cycle after the read strobe only
        nxt_ff.rdata = 32'h00000000;
        if (bus_req.rd) begin
            case (bus_req.addr)
                `REG_IE_CLEAR, `REG_IE_SET: begin
                    nxt_ff.rdata = cur_ff.ie;
                end

                `REG_INT_FLAG: begin
                    nxt_ff.rdata = cur_ff.flags;
                end

                `REG_OSC_CTRL: begin
                    // Enable reads one only once on, and stays one while stopping
                    nxt_ff.rdata[`OSC_ENABLE_BIT] = (cur_ff.osc_state == clk_src_pkg::OSC_ON) ||
                        (cur_ff.osc_state == clk_src_pkg::OSC_STOPPING);
                    nxt_ff.rdata[`OSC_RUN_IN_SLEEP_BIT] = cur_ff.osc_run_in_sleep;
                    nxt_ff.rdata[`OSC_ON_REQUEST_BIT] = cur_ff.osc_on_request;
                end

                `REG_FLL_CTRL: begin
                    nxt_ff.rdata = {16'h0000, cur_ff.fll_ctrl};
                end

                `REG_FLL_VALUE: begin
                    nxt_ff.rdata = {cur_ff.fll_count_difference, cur_ff.coarse, cur_ff.fine};
                end

                `REG_FLL_MUL: begin
                    nxt_ff.rdata = cur_ff.fll_mul;
                end

                `REG_PLL_CTRL: begin
                    nxt_ff.rdata[`PLL_ENABLE_BIT] = cur_ff.pll_en;
                    nxt_ff.rdata[`PLL_REF_LSB +: 2] = cur_ff.pll_ref_sel;
                end

                `REG_PLL_RATIO: begin
                    nxt_ff.rdata[11:0] = cur_ff.pll_int;
                    nxt_ff.rdata[`PLL_FRAC_LSB +: 4] = cur_ff.pll_frac;
                end

                `REG_PLL_STATUS: begin
                    nxt_ff.rdata[0] = cur_ff.pll_lock;
                    nxt_ff.rdata[1] = cur_ff.pll_en;
                end

                default: begin
                    // Unmapped addresses read as zero
                    nxt_ff.rdata = 32'h00000000;
                end
            endcase
        end

        // Interrupt enables: writing one sets, zero leaves alone
        if (wr_hit && bus_req.addr == `REG_IE_SET) begin
            nxt_ff.ie = cur_ff.ie | (wd & `IE_MASK);
        end

        // Separate clear register so software can turn enables back off
        if (wr_hit && bus_req.addr == `REG_IE_CLEAR) begin
            nxt_ff.ie = cur_ff.ie & ~(wd & `IE_MASK);
        end

        if (wr_hit && bus_req.addr == `REG_INT_FLAG) begin
            flag_clr = wd & `IE_MASK;
        end

        // PLL control; reference changes are software's job to do while disabled
        pll_start = 1'b0;
        ratio_wr = 1'b0;
        if (wr_hit && bus_req.addr == `REG_PLL_CTRL) begin
            nxt_ff.pll_en = wd[`PLL_ENABLE_BIT];
            pll_start = wd[`PLL_ENABLE_BIT] && !cur_ff.pll_en;
            // Reference select is simply stored; switching while running is not guarded
            nxt_ff.pll_ref_sel = wd[`PLL_REF_LSB +: 2];
        end

        // Ratio accepted at any time, also while running
        if (wr_hit && bus_req.addr == `REG_PLL_RATIO) begin
            nxt_ff.pll_int = wd[11:0];
            nxt_ff.pll_frac = wd[`PLL_FRAC_LSB +: 4];
            ratio_wr = cur_ff.pll_en;
        end

        // PLL lock tracking
        if (!nxt_ff.pll_en || pll_start || ratio_wr) begin
            // Any restart drops lock and starts settling again
            nxt_ff.pll_lock = 1'b0;
            nxt_ff.pll_cnt = 12'h000;
            nxt_ff.pll_to_done = 1'b0;
        end else if (cur_ff.pll_lock) begin
            // Losing the reference drops lock
            if (!cur_ff.ref_s2) begin
                nxt_ff.pll_lock = 1'b0;
                nxt_ff.pll_cnt = 12'h000;
            end
        end else begin
            if (cur_ff.pll_cnt != PLL_TIMEOUT_CYC) begin
                nxt_ff.pll_cnt = cur_ff.pll_cnt + 12'h001;
            end
            // Hardware sets lock again once settled
            if (cur_ff.ref_s2 && cur_ff.pll_cnt >= PLL_LOCK_CYC) begin
                nxt_ff.pll_lock = 1'b1;
            end else if (cur_ff.pll_cnt == PLL_TIMEOUT_CYC && !cur_ff.pll_to_done) begin
                // Timeout reported once per attempt
                flag_set[`BIT_LOCK_TIMEOUT] = 1'b1;
                nxt_ff.pll_to_done = 1'b1;
            end
        end

        flag_set[`BIT_LOCK_RISE] = nxt_ff.pll_lock && !cur_ff.pll_lock;
        flag_set[`BIT_LOCK_FALL] = !nxt_ff.pll_lock && cur_ff.pll_lock;

        // Supply monitor synchronisation finished: rising edge of the synced input
        flag_set[`BIT_SUPPLY_SYNC] = cur_ff.sup_s2 && !cur_ff.sup_s3;

        // Flags: a set in the same cycle as a clear wins
        nxt_ff.flags = (cur_ff.flags & ~flag_clr) | flag_set;

        // Request whenever an enabled flag is set
        nxt_ff.irq = |(nxt_ff.flags & nxt_ff.ie);

        // Internal oscillator control register
        if (wr_hit && bus_req.addr == `REG_OSC_CTRL) begin
            nxt_ff.osc_en_cfg = wd[`OSC_ENABLE_BIT];
            nxt_ff.osc_run_in_sleep = wd[`OSC_RUN_IN_SLEEP_BIT];
            nxt_ff.osc_on_request = wd[`OSC_ON_REQUEST_BIT];
        end

        // Enable handshake; a toggle mid-transition waits for the settled state
        case (cur_ff.osc_state)
            clk_src_pkg::OSC_OFF: begin
                if (nxt_ff.osc_en_cfg) begin
                    nxt_ff.osc_state = clk_src_pkg::OSC_STARTING;
                    nxt_ff.osc_cnt = 8'h00;
                end
            end

            clk_src_pkg::OSC_STARTING: begin
                nxt_ff.osc_cnt = cur_ff.osc_cnt + 8'h01;
                if (cur_ff.osc_cnt == OSC_SETTLE_CYC - 8'h01) begin
                    nxt_ff.osc_state = clk_src_pkg::OSC_ON;
                end
            end

            clk_src_pkg::OSC_ON: begin
                if (!nxt_ff.osc_en_cfg) begin
                    nxt_ff.osc_state = clk_src_pkg::OSC_STOPPING;
                    nxt_ff.osc_cnt = 8'h00;
                end
            end

            clk_src_pkg::OSC_STOPPING: begin
                nxt_ff.osc_cnt = cur_ff.osc_cnt + 8'h01;
                if (cur_ff.osc_cnt == OSC_SETTLE_CYC - 8'h01) begin
                    nxt_ff.osc_state = clk_src_pkg::OSC_OFF;
                end
            end

            default: begin
                nxt_ff.osc_state = clk_src_pkg::OSC_OFF;
            end
        endcase

        // Whether the oscillator should run given mode and sleep state
        if (standby && !cur_ff.osc_run_in_sleep) begin
            osc_demand = 1'b0;
        end else if (cur_ff.osc_on_request) begin
            // On-request mode, awake or in standby with run-in-sleep
            osc_demand = cur_ff.req_s2;
        end else begin
            osc_demand = 1'b1;
        end

        nxt_ff.osc_run = osc_demand && (cur_ff.osc_state == clk_src_pkg::OSC_STARTING ||
            cur_ff.osc_state == clk_src_pkg::OSC_ON);

        // Loop control and multiplier registers
        if (wr_hit && bus_req.addr == `REG_FLL_CTRL) begin
            nxt_ff.fll_ctrl = wd[15:0];
        end

        if (wr_hit && bus_req.addr == `REG_FLL_MUL) begin
            nxt_ff.fll_mul = wd;
        end

        fll_closed = cur_ff.fll_ctrl[`FLL_ENABLE_BIT] && cur_ff.fll_ctrl[`FLL_MODE_BIT];

        // Calibration writable only in open loop; difference field is never written by software
        if (wr_hit && bus_req.addr == `REG_FLL_VALUE && !cur_ff.fll_ctrl[`FLL_MODE_BIT]) begin
            nxt_ff.coarse = wd[15:10];
            nxt_ff.fine = wd[9:0];
        end

        // Reference period from the clock divider; output ticks counted within it
        ref_tick = fll_closed && (cur_ff.ref_cnt == FLL_REF_CYC - 12'h001);
        new_fll_count_difference = cur_ff.fll_mul[15:0] - cur_ff.tick_cnt;
        mag = new_fll_count_difference[15] ? 16'(-new_fll_count_difference) : new_fll_count_difference;

        // Coarse step: error scaled down, at least one unless the limit is zero, at most the coarse limit
        c_step = (mag[15:8] > {2'b00, cur_ff.fll_mul[31:26]}) ? cur_ff.fll_mul[31:26] : mag[13:8];
        if (c_step == 6'h00) begin
            c_step = 6'h01;
        end
        if (c_step > cur_ff.fll_mul[31:26]) begin
            c_step = cur_ff.fll_mul[31:26];
        end

        // Fine step: the error itself, at most the fine limit
        f_step = (mag > {6'h00, cur_ff.fll_mul[25:16]}) ? cur_ff.fll_mul[25:16] : mag[9:0];

        c_sum = 7'h00;
        f_sum = 11'h000;
        if (!fll_closed) begin
            // Open loop: counters idle, difference keeps its last value
            nxt_ff.ref_cnt = 12'h000;
            nxt_ff.tick_cnt = 16'h0000;
        end else if (ref_tick) begin
            nxt_ff.ref_cnt = 12'h000;
            nxt_ff.tick_cnt = 16'h0000;
            nxt_ff.fll_count_difference = new_fll_count_difference;
            if (mag >= `FLL_COARSE_THRESH) begin
                // Large error: move coarse, saturating at both ends
                if (!new_fll_count_difference[15]) begin
                    c_sum = {1'b0, cur_ff.coarse} + {1'b0, c_step};
                    nxt_ff.coarse = c_sum[6] ? 6'h3F : c_sum[5:0];
                end else begin
                    c_sum = {1'b0, cur_ff.coarse} - {1'b0, c_step};
                    nxt_ff.coarse = c_sum[6] ? 6'h00 : c_sum[5:0];
                end
            end else begin
                // Small error: move fine, saturating at both ends
                if (!new_fll_count_difference[15]) begin
                    f_sum = {1'b0, cur_ff.fine} + {1'b0, f_step};
                    nxt_ff.fine = f_sum[10] ? 10'h3FF : f_sum[9:0];
                end else begin
                    f_sum = {1'b0, cur_ff.fine} - {1'b0, f_step};
                    nxt_ff.fine = f_sum[10] ? 10'h000 : f_sum[9:0];
                end
            end
        end else begin
            nxt_ff.ref_cnt = cur_ff.ref_cnt + 12'h001;
            // Count rising edges of the synchronised output tick, holding at the top
            if (cur_ff.tick_s2 && !cur_ff.tick_s3 && cur_ff.tick_cnt != 16'hFFFF) begin
                nxt_ff.tick_cnt = cur_ff.tick_cnt + 16'h0001;
            end
        end
    end

    // State register with synchronous reset
    always_ff @(posedge clk) begin
        if (srst) begin
            cur_ff <= '0;
            cur_ff.osc_state <= clk_src_pkg::OSC_OFF;
            cur_ff.osc_en_cfg <= 1'(`OSC_CTRL_RESET >> `OSC_ENABLE_BIT);
            cur_ff.osc_run_in_sleep <= 1'b0;
            cur_ff.osc_on_request <= 1'b1;
            cur_ff.fll_ctrl <= `FLL_CTRL_RESET;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

endmodule
`default_nettype wire

// ---- tb/clk_src_monitor.sv ----
// Port checks for the clock source control block
`include "clk_src_regs.svh"
`default_nettype none
module clk_src_monitor (
    input wire logic clk,
    input wire logic srst,
    input wire clk_src_pkg::bus_req_s bus_req,
    input wire logic osc_request,
    input wire logic standby,
    input wire logic osc_run,
    input wire logic pll_enable,
    input wire logic pll_lock,
    input wire logic fll_enable,
    input wire logic fll_closed_loop,
    input wire logic [5:0] fll_coarse,
    input wire logic [9:0] fll_fine
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    logic sleep_ff; // Copy of the run-in-sleep setting
    logic on_req_ff; // Copy of the on-request setting
    logic [5:0] fll_coarse_step_max_ff; // Copy of the coarse step limit
    logic [9:0] fll_fine_step_max_ff; // Copy of the fine step limit
    logic wr_osc, wr_mul, wr_val, wr_ctl, wr_ratio; // Decoded writes
    assign wr_osc = bus_req.wr && bus_req.addr == `REG_OSC_CTRL;
    assign wr_mul = bus_req.wr && bus_req.addr == `REG_FLL_MUL;
    assign wr_val = bus_req.wr && bus_req.addr == `REG_FLL_VALUE;
    assign wr_ctl = bus_req.wr && bus_req.addr == `REG_FLL_CTRL;
    assign wr_ratio = bus_req.wr && bus_req.addr == `REG_PLL_RATIO;

    // Settings are shadowed from writes, since the checks cannot see inside the block
    always_ff @(posedge clk) begin
        if (srst) begin
            sleep_ff <= 1'b0;
            on_req_ff <= 1'b1;
            fll_coarse_step_max_ff <= 6'h00;
            fll_fine_step_max_ff <= 10'h000;
        end else begin
            if (wr_osc) begin
                sleep_ff <= bus_req.wdata[6];
                on_req_ff <= bus_req.wdata[7];
            end
            if (wr_mul) begin
                fll_coarse_step_max_ff <= bus_req.wdata[31:26];
                fll_fine_step_max_ff <= bus_req.wdata[25:16];
            end
        end
    end

    chk_ratio_drops_lock: assert property (wr_ratio && pll_enable |=> !pll_lock)
        else $error("lock held after ratio write");
    chk_sleep_stops_osc: assert property (standby && !sleep_ff |=> !osc_run)
        else $error("oscillator ran in standby");
    chk_request_gates: assert property ((on_req_ff && !osc_request) [*5] |-> !osc_run)
        else $error("oscillator ran without request");
    chk_mode_select: assert property (wr_ctl |=> fll_closed_loop == $past(bus_req.wdata[2]))
        else $error("loop mode not taken");
    chk_cal_open: assert property (wr_val && !fll_closed_loop && !fll_enable
        |=> {fll_coarse, fll_fine} == $past(bus_req.wdata[15:0]))
        else $error("calibration write lost");
    chk_cal_closed: assert property (wr_val && fll_closed_loop && !fll_enable
        |=> $stable({fll_coarse, fll_fine}))
        else $error("calibration changed in closed loop");
    chk_coarse_step: assert property (fll_closed_loop && fll_enable && !$past(bus_req.wr) |->
        (fll_coarse >= $past(fll_coarse) ? fll_coarse - $past(fll_coarse) : $past(fll_coarse) - fll_coarse) <= fll_coarse_step_max_ff)
        else $error("coarse step too large");
    chk_fine_step: assert property (fll_closed_loop && fll_enable && !$past(bus_req.wr) |->
        (fll_fine >= $past(fll_fine) ? fll_fine - $past(fll_fine) : $past(fll_fine) - fll_fine) <= fll_fine_step_max_ff)
        else $error("fine step too large");
endmodule
`default_nettype wire

// ---- tb/system_clock_source_control_tb.sv ----
// Self-checking bench for the clock source control block
`include "clk_src_regs.svh"
`default_nettype none
module system_clock_source_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, srst, osc_request, standby, pll_ref_ok, supply_sync_done, fll_out_tick, rd_seen;
    clk_src_pkg::bus_req_s bus_req; // Register port request
    logic [31:0] rdata, ie, r;
    logic irq, osc_run, pll_enable, pll_lock, fll_enable, fll_closed_loop;
    logic [1:0] pll_ref_sel;
    logic [11:0] pll_int;
    logic [3:0] pll_frac;
    logic [5:0] fll_coarse;
    logic [9:0] fll_fine;
    logic [31:0] exp_q[$]; // Expected read data, oldest first
    int fail_count, samples_checked;
    int bits[4] = '{17, 16, 15, 11}; // Enable bits of the set register

    system_clock_source_control u_dut (.clk(clk), .srst(srst), .bus_req(bus_req), .rdata(rdata),
        .osc_request(osc_request), .standby(standby), .pll_ref_ok(pll_ref_ok),
        .supply_sync_done(supply_sync_done), .fll_out_tick(fll_out_tick), .irq(irq), .osc_run(osc_run),
        .pll_enable(pll_enable), .pll_ref_sel(pll_ref_sel), .pll_int(pll_int), .pll_frac(pll_frac),
        .pll_lock(pll_lock), .fll_enable(fll_enable), .fll_closed_loop(fll_closed_loop),
        .fll_coarse(fll_coarse), .fll_fine(fll_fine));

    // 20 MHz clock
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            $display("wrong value at %0t ns: saw %h expected %h", $time, seen, exp);
            fail_count++;
        end
    endtask

    task automatic close_out();
        $display("compares %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // One-cycle write; the strobe drops at the edge that takes it
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        bus_req <= '{a, d, 1'b1, 1'b0};
        @(posedge clk);
        bus_req.wr <= 1'b0;
    endtask

    // One-cycle read; the expected word is noted for the watcher
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        bus_req <= '{a, 32'h00000000, 1'b0, 1'b1};
        @(posedge clk);
        bus_req.rd <= 1'b0;
    endtask

    function automatic logic [31:0] probe(input int s);
        case (s)
            0: return 32'(pll_lock);
            1: return 32'(fll_coarse);
            2: return 32'(fll_fine);
            3: return 32'(irq);
            default: return 32'(osc_run);
        endcase
    endfunction

    // Bounded wait for an output to reach a value
    task automatic wait_for(input int s, input logic [31:0] v, input int lim);
        int n;
        n = 0;
        while (probe(s) !== v && n < lim) begin
            @(negedge clk);
            n++;
        end
        if (probe(s) !== v) begin
            $display("wrong value at %0t ns: wait ran out", $time);
            fail_count++;
            close_out();
        end
    endtask

    // Look at an output n edges later, mid-cycle where it is settled
    task automatic after(input int n, input int s, input logic [31:0] v);
        repeat (n) @(posedge clk);
        @(negedge clk);
        check(probe(s), v);
    endtask

    task automatic done(input string s);
        $display("test %s finished", s);
    endtask

    // Read data stand only in the cycle after the strobe
    always @(posedge clk) rd_seen <= bus_req.rd;
    always @(negedge clk) begin
        if (rd_seen && exp_q.size() > 0) begin
            check(rdata, exp_q.pop_front());
        end else if (rd_seen) begin
            fail_count++;
        end
    end

    initial begin
        srst = 1'b1;
        bus_req = '0;
        {osc_request, standby, supply_sync_done, fll_out_tick} = 4'h0;
        pll_ref_ok = 1'b1;
        r = $urandom(32'hE60E70D7);
        repeat (3) @(posedge clk);
        srst <= 1'b0;
        rd(`REG_FLL_CTRL, 32'h00000080);
        rd(`REG_OSC_CTRL, 32'h00000080);
        rd(`REG_FLL_MUL, 32'h00000000);
        rd(8'h10, 32'h00000000); // Unmapped place reads zero
        done("reset");
        ie = 32'h00000000;
        for (int i = 0; i < 4; i++) begin
            wr(`REG_IE_SET, 32'h00000001 << bits[i]);
            ie = ie | (32'h00000001 << bits[i]);
            rd(`REG_IE_CLEAR, ie);
        end
        wr(`REG_IE_SET, 32'h00000000);
        rd(`REG_IE_CLEAR, ie);
        wr(`REG_IE_CLEAR, `IE_MASK);
        r = $urandom();
        wr(`REG_IE_SET, r);
        rd(`REG_IE_CLEAR, r & `IE_MASK);
        wr(`REG_IE_CLEAR, `IE_MASK);
        done("enable set");
        // Flag raised while masked, then unmasked, then cleared
        @(posedge clk) supply_sync_done <= 1'b1;
        after(6, 3, 32'h00000000);
        rd(`REG_INT_FLAG, 32'h00000800);
        supply_sync_done <= 1'b0;
        wr(`REG_IE_SET, 32'h00018800);
        after(0, 3, 32'h00000001);
        wr(`REG_INT_FLAG, `IE_MASK);
        after(0, 3, 32'h00000000);
        done("interrupt");
        wr(`REG_PLL_CTRL, 32'h00000000);
        wr(`REG_PLL_CTRL, 32'h00000020);
        wr(`REG_PLL_CTRL, 32'h00000022);
        wait_for(0, 32'h00000001, 400);
        check(32'({pll_enable, pll_ref_sel}), 32'h00000006);
        after(0, 3, 32'h00000001);
        rd(`REG_PLL_STATUS, 32'h00000003);
        wr(`REG_INT_FLAG, `IE_MASK);
        wr(`REG_PLL_RATIO, 32'h00050123);
        after(0, 0, 32'h00000000);
        check(32'({pll_frac, pll_int}), 32'h00005123);
        wait_for(3, 32'h00000001, 4);
        wait_for(0, 32'h00000001, 400);
        rd(`REG_INT_FLAG, 32'h00018000);
        done("pll");
        wr(`REG_OSC_CTRL, 32'h00000002);
        rd(`REG_OSC_CTRL, 32'h00000000);
        after(1, 4, 32'h00000001);
        repeat (25) @(posedge clk);
        rd(`REG_OSC_CTRL, 32'h00000002);
        @(posedge clk) standby <= 1'b1;
        after(1, 4, 32'h00000000);
        wr(`REG_OSC_CTRL, 32'h000000C2);
        after(2, 4, 32'h00000000);
        @(posedge clk) osc_request <= 1'b1;
        after(5, 4, 32'h00000001);
        @(posedge clk) {standby, osc_request} <= 2'b00;
        after(5, 4, 32'h00000000);
        wr(`REG_OSC_CTRL, 32'h00000002);
        after(2, 4, 32'h00000001);
        wr(`REG_OSC_CTRL, 32'h00000000);
        rd(`REG_OSC_CTRL, 32'h00000002);
        repeat (25) @(posedge clk);
        rd(`REG_OSC_CTRL, 32'h00000000);
        done("oscillator");
        wr(`REG_FLL_VALUE, 32'h0000140A);
        after(0, 1, 32'h00000005);
        wr(`REG_FLL_MUL, 32'h08050300);
        wr(`REG_FLL_CTRL, 32'h00000004);
        wr(`REG_FLL_VALUE, 32'h00000000);
        after(0, 2, 32'h0000000A);
        wr(`REG_FLL_CTRL, 32'h00000006);
        wait_for(1, 32'h00000007, 300);
        rd(`REG_FLL_VALUE, 32'h03001C0A);
        wr(`REG_FLL_MUL, 32'h08050050);
        wait_for(2, 32'h0000000F, 300);
        rd(`REG_FLL_VALUE, 32'h00501C0F);
        done("loop");
        close_out();
    end
endmodule

bind system_clock_source_control clk_src_monitor u_mon (.clk(clk), .srst(srst), .bus_req(bus_req),
    .osc_request(osc_request), .standby(standby), .osc_run(osc_run), .pll_enable(pll_enable),
    .pll_lock(pll_lock), .fll_enable(fll_enable), .fll_closed_loop(fll_closed_loop),
    .fll_coarse(fll_coarse), .fll_fine(fll_fine));
`default_nettype wire
